// ==== smd_addr_decoder.sv ====
// Summary of operation
// [R1] io fffc-ffff hits base register, cpu only
// [R2] config region defaults to 4k at fffef000
// [R3] base register aliases region below 1 gbyte
// [R4] io 0cf8-0cff is pci config, cpu only
// [R5] pci config reached via io address/data ports
// [R6] io 0000-03ff always hits pc/at peripherals
// [R7] sdram linear from zero, at most 256m
// [R8] boot rom select at top 64k, cpu
// [R9] above sdram top defaults to pci bus
// [R10] unclaimed cpu io goes to pci io
// [R11] gp memory regions only below 1 gbyte
// [R12] gp io regions below 64k, not peripherals
// [R13] pci io both masters, gp io cpu only
// [R14] only descriptors 0 and 1 redirect to pci
// [R15] sixteen descriptors, lowest number wins overlap
// [R16] descriptors are 32-bit config region registers
// [R17] descriptor: target, attribute, page bit, extent
// [R18] attribute: protection/cacheability or gp chip select
// [R19] extent field gives start and size
// [R20] descriptors pick space only, no timing
// [R21] software keeps alias off low pci windows
// [R22] protected pci-master write masked and purged
// [R23] gp memory always noncacheable, no attributes
// [R24] parallel match, one target per access
module smd_addr_decoder (
  // ----------------------------------------------------------------
  // clock and reset
  // ----------------------------------------------------------------
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // ----------------------------------------------------------------
  // sdram controller setting, same clock
  // ----------------------------------------------------------------
  input wire logic [31:0] sdram_top_in,
  // ----------------------------------------------------------------
  // cpu access
  // ----------------------------------------------------------------
  input wire smd_pkg::smd_req_t cpu_req_in,
  output smd_pkg::smd_cpu_resp_t cpu_resp_out,
  // ----------------------------------------------------------------
  // pci master access
  // ----------------------------------------------------------------
  input wire smd_pkg::smd_req_t pci_req_in,
  output smd_pkg::smd_pci_resp_t pci_resp_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [smd_pkg::DESC_COUNT-1:0][31:0] desc;
    logic [31:0] config_region_base;
    smd_pkg::smd_cpu_resp_t cpu;
    smd_pkg::smd_pci_resp_t pci;
  } smd_state_t;

  smd_state_t s_r;
  smd_state_t s_nxt;

  logic [smd_pkg::DESC_COUNT-1:0] cpu_hit;
  logic [smd_pkg::DESC_COUNT-1:0] pci_hit;

  // ----------------------------------------------------------------
  // descriptor matchers, all evaluated in parallel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < smd_pkg::DESC_COUNT; i++)
  begin : g_match
    smd_region_match #(
      .ALLOW_PCI(i < 2)
    ) u_cpu_match (
      .desc_in(s_r.desc[i]),
      .addr_in(cpu_req_in.addr),
      .io_in(cpu_req_in.io),
      .hit_out(cpu_hit[i])
    ); // R24
    smd_region_match #(
      .ALLOW_PCI(i < 2)
    ) u_pci_match (
      .desc_in(s_r.desc[i]),
      .addr_in(pci_req_in.addr),
      .io_in(1'b0),
      .hit_out(pci_hit[i])
    );
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] top;
    logic [31:0] a;
    logic [15:0] ioa;
    logic cfound;
    logic [3:0] cwin;
    logic pfound;
    logic [3:0] pwin;
    logic [31:0] cdesc;
    logic [31:0] pdesc;
    smd_pkg::smd_tgt_t ctgt;
    smd_pkg::smd_tgt_t ptgt;
    logic [2:0] cattr;
    logic in_boot;
    logic in_mapped_config_region_def;
    logic in_alias;
    logic below_top;
    logic mapped_config_region_sel;
    logic [11:0] ofs;
    logic desc_ofs;
    logic [3:0] didx;

    s_nxt = s_r;
    top = (sdram_top_in > smd_pkg::SDRAM_MAX_TOP) ? smd_pkg::SDRAM_MAX_TOP : sdram_top_in; // R7
    a = cpu_req_in.addr;
    ioa = cpu_req_in.addr[15:0];
    cfound = 1'b0;
    cwin = 4'h0;
    pfound = 1'b0;
    pwin = 4'h0;
    // lowest-numbered match wins
    for (int i = smd_pkg::DESC_COUNT - 1; i >= 0; i--)
    begin
      if (cpu_hit[i])
      begin
        cfound = 1'b1;
        cwin = 4'(i);
      end
      if (pci_hit[i])
      begin
        pfound = 1'b1;
        pwin = 4'(i);
      end
    end // R15
    cdesc = s_r.desc[cwin];
    pdesc = s_r.desc[pwin];
    ctgt = smd_pkg::smd_tgt_t'(cdesc[smd_pkg::TGT_LSB +: 3]); // R17
    ptgt = smd_pkg::smd_tgt_t'(pdesc[smd_pkg::TGT_LSB +: 3]);
    cattr = cdesc[smd_pkg::REGION_ATTRIBUTE_FIELD_LSB +: 3];
    in_boot = (a >= smd_pkg::BOOT_WIN_BASE);
    in_mapped_config_region_def = ((a & smd_pkg::MAPPED_CONFIG_REGION_PAGE_MASK) == smd_pkg::MAPPED_CONFIG_REGION_DEFAULT_BASE); // R2
    in_alias = s_r.config_region_base[smd_pkg::CONFIG_REGION_BASE_EN_BIT] && (a[31:30] == 2'b00) &&
      (a[smd_pkg::CONFIG_REGION_BASE_BASE_MSB:smd_pkg::CONFIG_REGION_BASE_BASE_LSB] ==
       s_r.config_region_base[smd_pkg::CONFIG_REGION_BASE_BASE_MSB:smd_pkg::CONFIG_REGION_BASE_BASE_LSB]); // R3
    below_top = (a < top);
    ofs = a[11:0];
    desc_ofs = (ofs >= smd_pkg::DESC_FIRST_OFS) && (ofs <= smd_pkg::DESC_LAST_OFS) &&
      (ofs[1:0] == 2'b00);
    didx = 4'((ofs - smd_pkg::DESC_FIRST_OFS) >> smd_pkg::DESC_IDX_LSB);
    mapped_config_region_sel = 1'b0;

    // ----------------------------------------------------------------
    // cpu side: one route per access
    // ----------------------------------------------------------------
    s_nxt.cpu.valid = cpu_req_in.valid;
    s_nxt.cpu.route = smd_pkg::RT_NONE;
    s_nxt.cpu.chip_sel = 3'h0;
    s_nxt.cpu.write_protect = 1'b0;
    s_nxt.cpu.noncache = 1'b0;
    s_nxt.cpu.nonexec = 1'b0;
    s_nxt.cpu.rdata = 32'h00000000;
    if (!cpu_req_in.valid)
    begin
      s_nxt.cpu.route = smd_pkg::RT_NONE;
    end
    else if (cpu_req_in.io)
    begin
      if ((ioa & smd_pkg::CONFIG_REGION_BASE_IO_MASK) == smd_pkg::CONFIG_REGION_BASE_IO_ADDR)
      begin
        s_nxt.cpu.route = smd_pkg::RT_CONFIG_REGION_BASE; // R1
        s_nxt.cpu.rdata = s_r.config_region_base;
        if (cpu_req_in.write)
        begin
          s_nxt.config_region_base = cpu_req_in.wdata & smd_pkg::CONFIG_REGION_BASE_WR_MASK;
        end
      end
      else if (ioa <= smd_pkg::PCAT_IO_TOP)
      begin
        s_nxt.cpu.route = smd_pkg::RT_PCAT_IO; // R6
      end
      else if ((ioa & smd_pkg::PCICFG_IO_MASK) == smd_pkg::PCICFG_IO_ADDR)
      begin
        s_nxt.cpu.route = smd_pkg::RT_PCI_CFG; // R4 R5
      end
      else if (cfound)
      begin
        s_nxt.cpu.route = smd_pkg::RT_GP_IO; // R13
        s_nxt.cpu.chip_sel = cattr; // R18
        s_nxt.cpu.noncache = 1'b1;
      end
      else
      begin
        s_nxt.cpu.route = smd_pkg::RT_PCI_IO; // R10 R13
        s_nxt.cpu.noncache = 1'b1;
      end
    end
    else if (in_boot)
    begin
      // the default boot window cannot be turned off
      s_nxt.cpu.route = smd_pkg::RT_ROM_BOOT; // R8
    end
    else if (in_mapped_config_region_def)
    begin
      mapped_config_region_sel = 1'b1;
    end
    else if (cfound && (ctgt == smd_pkg::TGT_PCI) && below_top)
    begin
      // a low pci window outranks the alias; overlap is a software fault
      s_nxt.cpu.route = smd_pkg::RT_PCI_MEM; // R14 R21
      s_nxt.cpu.noncache = 1'b1;
    end
    else if (in_alias)
    begin
      mapped_config_region_sel = 1'b1;
    end
    else if (cfound)
    begin
      // only the address space comes from here; timing lives elsewhere
      case (ctgt) // R20
        smd_pkg::TGT_GP_MEM:
        begin
          s_nxt.cpu.route = smd_pkg::RT_GP_MEM;
          s_nxt.cpu.chip_sel = cattr; // R18
          s_nxt.cpu.noncache = 1'b1; // R23
        end
        smd_pkg::TGT_PCI:
        begin
          s_nxt.cpu.route = smd_pkg::RT_PCI_MEM; // R9
          s_nxt.cpu.noncache = 1'b1;
        end
        default:
        begin
          case (ctgt)
            smd_pkg::TGT_BOOT: s_nxt.cpu.route = smd_pkg::RT_ROM_BOOT;
            smd_pkg::TGT_ROM1: s_nxt.cpu.route = smd_pkg::RT_ROM1;
            smd_pkg::TGT_ROM2: s_nxt.cpu.route = smd_pkg::RT_ROM2;
            default: s_nxt.cpu.route = smd_pkg::RT_SDRAM;
          endcase
          s_nxt.cpu.write_protect = cattr[smd_pkg::REGION_ATTRIBUTE_FIELD_WP]; // R18
          s_nxt.cpu.noncache = cattr[smd_pkg::REGION_ATTRIBUTE_FIELD_NC];
          s_nxt.cpu.nonexec = cattr[smd_pkg::REGION_ATTRIBUTE_FIELD_NX];
        end
      endcase
    end
    else if (below_top)
    begin
      s_nxt.cpu.route = smd_pkg::RT_SDRAM; // R7
    end
    else
    begin
      s_nxt.cpu.route = smd_pkg::RT_PCI_MEM; // R9
      s_nxt.cpu.noncache = 1'b1;
    end

    // ----------------------------------------------------------------
    // config region register access
    // ----------------------------------------------------------------
    if (mapped_config_region_sel)
    begin
      s_nxt.cpu.route = smd_pkg::RT_MAPPED_CONFIG_REGION;
      s_nxt.cpu.noncache = 1'b1;
      if (desc_ofs)
      begin
        s_nxt.cpu.rdata = s_r.desc[didx]; // R16
        if (cpu_req_in.write)
        begin
          s_nxt.desc[didx] = cpu_req_in.wdata;
        end
      end
    end

    // ----------------------------------------------------------------
    // pci master side: only sdram space is claimed
    // ----------------------------------------------------------------
    s_nxt.pci.valid = pci_req_in.valid;
    s_nxt.pci.claim = 1'b0;
    s_nxt.pci.mask_bytes = 1'b0;
    s_nxt.pci.purge = 1'b0;
    // pci io and everything above the sdram top stays on the pci bus
    if (pci_req_in.valid && !pci_req_in.io && (pci_req_in.addr < top) &&
        !(pfound && (ptgt == smd_pkg::TGT_PCI))) // R13 R9
    begin
      s_nxt.pci.claim = 1'b1;
      // redirected or protected regions still run an sdram cycle, masked only for writes
      if (pfound && ((ptgt != smd_pkg::TGT_SDRAM) ||
          pdesc[smd_pkg::REGION_ATTRIBUTE_FIELD_LSB + smd_pkg::REGION_ATTRIBUTE_FIELD_WP]))
      begin
        s_nxt.pci.mask_bytes = pci_req_in.write; // R22
        s_nxt.pci.purge = pci_req_in.write;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      s_r <= '0;
      for (int i = 0; i < smd_pkg::DESC_COUNT; i++)
      begin
        s_r.desc[i] <= smd_pkg::DESC_RESET;
      end
      s_r.config_region_base <= smd_pkg::CONFIG_REGION_BASE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign cpu_resp_out = s_r.cpu;
  assign pci_resp_out = s_r.pci;

endmodule // smd_addr_decoder

// ==== smd_pkg.sv ====
package smd_pkg;

  // ----------------------------------------------------------------
  // fixed address windows
  // ----------------------------------------------------------------
  localparam logic [31:0] MAPPED_CONFIG_REGION_DEFAULT_BASE = 32'hfffef000;
  localparam logic [31:0] MAPPED_CONFIG_REGION_PAGE_MASK = 32'hfffff000;
  localparam logic [31:0] BOOT_WIN_BASE = 32'hffff0000;
  localparam logic [31:0] SDRAM_MAX_TOP = 32'h10000000;
  localparam logic [33:0] LOW_GB_LIMIT = 34'h040000000;
  localparam logic [15:0] CONFIG_REGION_BASE_IO_ADDR = 16'hfffc;
  localparam logic [15:0] CONFIG_REGION_BASE_IO_MASK = 16'hfffc;
  localparam logic [15:0] PCAT_IO_TOP = 16'h03ff;
  localparam logic [15:0] PCICFG_IO_ADDR = 16'h0cf8;
  localparam logic [15:0] PCICFG_IO_MASK = 16'hfff8;

  // ----------------------------------------------------------------
  // descriptor register block inside the mapped config region
  // ----------------------------------------------------------------
  localparam int DESC_COUNT = 16;
  localparam logic [11:0] DESC_FIRST_OFS = 12'h088;
  localparam logic [11:0] DESC_LAST_OFS = 12'h0c4;
  localparam int DESC_IDX_LSB = 2;
  localparam logic [31:0] DESC_RESET = 32'h00000000;

  // descriptor field layout
  localparam int TGT_LSB = 29;
  localparam int REGION_ATTRIBUTE_FIELD_LSB = 26;
  localparam int PG_BIT = 25;
  localparam int MSIZE_LSB = 18;
  localparam int MSIZE_W = 7;
  localparam int MSTART_W = 18;
  localparam int ISIZE_LSB = 16;
  localparam int ISIZE_W = 9;
  localparam int ISTART_W = 16;
  localparam int SMALL_PAGE_SHIFT = 12;
  localparam int LARGE_PAGE_SHIFT = 16;

  // attribute bits for rom and sdram targets
  localparam int REGION_ATTRIBUTE_FIELD_WP = 0;
  localparam int REGION_ATTRIBUTE_FIELD_NC = 1;
  localparam int REGION_ATTRIBUTE_FIELD_NX = 2;

  // config region base register layout
  localparam int CONFIG_REGION_BASE_EN_BIT = 31;
  localparam int CONFIG_REGION_BASE_BASE_LSB = 12;
  localparam int CONFIG_REGION_BASE_BASE_MSB = 29;
  localparam logic [31:0] CONFIG_REGION_BASE_WR_MASK = 32'hbffff000;
  localparam logic [31:0] CONFIG_REGION_BASE_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_NONE, TGT_GP_IO, TGT_GP_MEM, TGT_PCI,
    TGT_BOOT, TGT_ROM1, TGT_ROM2, TGT_SDRAM
  } smd_tgt_t;

  typedef enum logic [3:0] {
    RT_NONE, RT_SDRAM, RT_ROM_BOOT, RT_ROM1, RT_ROM2, RT_GP_MEM, RT_GP_IO,
    RT_PCI_MEM, RT_PCI_IO, RT_PCI_CFG, RT_PCAT_IO, RT_CONFIG_REGION_BASE, RT_MAPPED_CONFIG_REGION
  } smd_route_t;

  typedef struct packed {
    logic valid;
    logic io;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } smd_req_t;

  typedef struct packed {
    logic valid;
    smd_route_t route;
    logic [2:0] chip_sel;
    logic write_protect;
    logic noncache;
    logic nonexec;
    logic [31:0] rdata;
  } smd_cpu_resp_t;

  typedef struct packed {
    logic valid;
    logic claim;
    logic mask_bytes;
    logic purge;
  } smd_pci_resp_t;

endpackage

// ==== smd_region_match.sv ====
module smd_region_match #(
  parameter bit ALLOW_PCI = 1'b0
) (
  // ----------------------------------------------------------------
  // descriptor and access
  // ----------------------------------------------------------------
  input wire logic [31:0] desc_in,
  input wire logic [31:0] addr_in,
  input wire logic io_in,
  // ----------------------------------------------------------------
  // result
  // ----------------------------------------------------------------
  output logic hit_out
);

  smd_pkg::smd_tgt_t tgt;
  logic [33:0] mbase;
  logic [33:0] mlimit;
  logic [33:0] maddr;
  logic [16:0] ibase;
  logic [16:0] ilimit;
  logic mem_tgt;

  always_comb
  begin
    tgt = smd_pkg::smd_tgt_t'(desc_in[smd_pkg::TGT_LSB +: 3]);
    maddr = {2'b00, addr_in};
    if (desc_in[smd_pkg::PG_BIT])
    begin
      mbase = 34'(desc_in[smd_pkg::MSTART_W-1:0]) << smd_pkg::LARGE_PAGE_SHIFT;
      mlimit = mbase + ((34'(desc_in[smd_pkg::MSIZE_LSB +: smd_pkg::MSIZE_W]) + 34'd1)
        << smd_pkg::LARGE_PAGE_SHIFT);
    end
    else
    begin
      mbase = 34'(desc_in[smd_pkg::MSTART_W-1:0]) << smd_pkg::SMALL_PAGE_SHIFT;
      mlimit = mbase + ((34'(desc_in[smd_pkg::MSIZE_LSB +: smd_pkg::MSIZE_W]) + 34'd1)
        << smd_pkg::SMALL_PAGE_SHIFT);
    end
    ibase = {1'b0, desc_in[smd_pkg::ISTART_W-1:0]};
    ilimit = ibase + 17'(desc_in[smd_pkg::ISIZE_LSB +: smd_pkg::ISIZE_W]) + 17'd1;
    // pci redirection only from the two highest-priority slots
    mem_tgt = (tgt == smd_pkg::TGT_GP_MEM) || (tgt == smd_pkg::TGT_BOOT) ||
      (tgt == smd_pkg::TGT_ROM1) || (tgt == smd_pkg::TGT_ROM2) ||
      (tgt == smd_pkg::TGT_SDRAM) || ((tgt == smd_pkg::TGT_PCI) && ALLOW_PCI); // R14
    if (io_in)
    begin
      // io regions live below 64k and never over the pc/at ports
      hit_out = (tgt == smd_pkg::TGT_GP_IO) && (addr_in[31:16] == 16'h0000) &&
        (addr_in[15:0] > smd_pkg::PCAT_IO_TOP) &&
        ({1'b0, addr_in[15:0]} >= ibase) && ({1'b0, addr_in[15:0]} < ilimit); // R12
    end
    else
    begin
      // regions that spill past 1 gbyte are ignored rather than wrapped
      hit_out = mem_tgt && (mlimit <= smd_pkg::LOW_GB_LIMIT) &&
        (maddr >= mbase) && (maddr < mlimit); // R11 R19
    end
  end

endmodule // smd_region_match

// ==== smd_addr_decoder_checker.sv ====
module smd_addr_decoder_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // watched ports
  input wire logic [31:0] sdram_top_in,
  input wire smd_pkg::smd_req_t cpu_req_in,
  input wire smd_pkg::smd_cpu_resp_t cpu_resp_out,
  input wire smd_pkg::smd_req_t pci_req_in,
  input wire smd_pkg::smd_pci_resp_t pci_resp_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic cpu_io_low;
  logic cpu_mem;
  // io decode only looks at the low 64k
  assign cpu_io_low = cpu_req_in.valid && cpu_req_in.io && cpu_req_in.addr[31:16] == 16'h0000;
  assign cpu_mem = cpu_req_in.valid && !cpu_req_in.io;
  sequence s_pci_wr;
    pci_req_in.valid && pci_req_in.write && !pci_req_in.io;
  endsequence
  sequence s_masked;
    pci_resp_out.valid && pci_resp_out.claim && pci_resp_out.mask_bytes;
  endsequence
  a_cpu_answer: assert property (cpu_req_in.valid |=> cpu_resp_out.valid)
    else $error("cpu access not answered");
  a_cpu_quiet: assert property (!cpu_req_in.valid |=> !cpu_resp_out.valid)
    else $error("cpu answer without access");
  a_pci_answer: assert property (pci_req_in.valid |=> pci_resp_out.valid)
    else $error("pci access not answered");
  a_pcat_fixed: assert property (cpu_io_low && cpu_req_in.addr[15:0] <= smd_pkg::PCAT_IO_TOP
    |=> cpu_resp_out.route == smd_pkg::RT_PCAT_IO) else $error("peripheral port misrouted");
  a_pcicfg_ports: assert property (cpu_io_low
    && (cpu_req_in.addr[15:0] & smd_pkg::PCICFG_IO_MASK) == smd_pkg::PCICFG_IO_ADDR
    |=> cpu_resp_out.route == smd_pkg::RT_PCI_CFG) else $error("pci config port misrouted");
  a_base_port: assert property (cpu_io_low
    && (cpu_req_in.addr[15:0] & smd_pkg::CONFIG_REGION_BASE_IO_MASK) == smd_pkg::CONFIG_REGION_BASE_IO_ADDR
    |=> cpu_resp_out.route == smd_pkg::RT_CONFIG_REGION_BASE) else $error("base port misrouted");
  a_boot_top: assert property (cpu_mem && cpu_req_in.addr >= smd_pkg::BOOT_WIN_BASE
    |=> cpu_resp_out.route == smd_pkg::RT_ROM_BOOT) else $error("boot window misrouted");
  a_high_pci: assert property (cpu_mem && cpu_req_in.addr >= 32'h40000000
    && cpu_req_in.addr < smd_pkg::MAPPED_CONFIG_REGION_DEFAULT_BASE
    |=> cpu_resp_out.route == smd_pkg::RT_PCI_MEM) else $error("high memory not on pci");
  a_pci_io_refused: assert property (pci_req_in.valid && pci_req_in.io
    |=> !pci_resp_out.claim) else $error("pci io claimed");
  a_masked_write: assert property (s_pci_wr ##1 s_masked |-> pci_resp_out.purge)
    else $error("masked write not purged");
  a_read_plain: assert property (pci_req_in.valid && !pci_req_in.write
    |=> !pci_resp_out.mask_bytes && !pci_resp_out.purge) else $error("pci read masked");
  a_gp_mem_plain: assert property (cpu_resp_out.valid
    && cpu_resp_out.route == smd_pkg::RT_GP_MEM
    |-> cpu_resp_out.noncache && !cpu_resp_out.write_protect) else $error("gp memory attrs");
endmodule // smd_addr_decoder_checker

bind smd_addr_decoder smd_addr_decoder_checker smd_addr_decoder_checker_inst (
  .ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in),
  .sdram_top_in(sdram_top_in),
  .cpu_req_in(cpu_req_in),
  .cpu_resp_out(cpu_resp_out),
  .pci_req_in(pci_req_in),
  .pci_resp_out(pci_resp_out)
);

// ==== smd_pci_master_model.sv ====
module smd_pci_master_model (
  // clock
  input wire logic ref_clk_in,
  // access to decoder
  output smd_pkg::smd_req_t pci_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pci_req_out = '0;
  // idle cycles model a slow master; released lines flip so stale values never match
  task automatic pci_access(input logic wr, input logic io, input logic [31:0] addr,
                            input int idle);
    repeat (idle) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    pci_req_out = '{1'b1, io, wr, addr, ~addr};
    @(negedge ref_clk_in);
    pci_req_out = '{1'b0, ~io, ~wr, ~addr, addr};
  endtask
endmodule // smd_pci_master_model

// ==== test_smd_addr_decoder.sv ====
module test_smd_addr_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in;
  logic reset_n_in;
  logic [31:0] sdram_top_in;
  smd_pkg::smd_req_t cpu_req_in;
  smd_pkg::smd_req_t pci_req_in;
  smd_pkg::smd_cpu_resp_t cpu_resp_out;
  smd_pkg::smd_pci_resp_t pci_resp_out;
  int n_mismatch = 0;
  int checks_done = 0;

  smd_addr_decoder smd_addr_decoder_inst (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .sdram_top_in(sdram_top_in),
    .cpu_req_in(cpu_req_in),
    .cpu_resp_out(cpu_resp_out),
    .pci_req_in(pci_req_in),
    .pci_resp_out(pci_resp_out)
  );
  smd_pci_master_model smd_pci_master_model_inst (
    .ref_clk_in(ref_clk_in),
    .pci_req_out(pci_req_in)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // ----
  // reporting
  // ----
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_cpu(input string what, input logic [4:0] exp, input logic [4:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_pci(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----
  // access tasks
  // ----
  task automatic cpu_go(input logic io, input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk_in);
    cpu_req_in = '{1'b1, io, wr, a, d};
    @(negedge ref_clk_in);
    cpu_req_in = '{1'b0, ~io, ~wr, ~a, ~d};
  endtask

  task automatic cpu_route(input logic io, input logic [31:0] a, input smd_pkg::smd_route_t r);
    cpu_go(io, 1'b0, a, 32'h00000000);
    cmp_cpu($sformatf("route %h", a), {1'b1, r}, {cpu_resp_out.valid, cpu_resp_out.route});
  endtask

  task automatic cpu_rd(input logic io, input logic [31:0] a, input logic [31:0] exp);
    cpu_go(io, 1'b0, a, 32'h00000000);
    cmp_word($sformatf("rdata %h", a), exp, cpu_resp_out.rdata);
  endtask

  task automatic desc_wr(input int n, input logic [31:0] d);
    cpu_go(1'b0, 1'b1, smd_pkg::MAPPED_CONFIG_REGION_DEFAULT_BASE + 32'(smd_pkg::DESC_FIRST_OFS) + 32'(4 * n), d);
  endtask

  task automatic pci(input logic wr, input logic io, input logic [31:0] a, input logic [3:0] exp);
    smd_pci_master_model_inst.pci_access(wr, io, a, wr ? 3 : 0);
    cmp_pci($sformatf("pci %h", a), exp, pci_resp_out);
  endtask

  initial
  begin
    repeat (3000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("watchdog expired");
    complete_run();
  end

  // ----
  // tests
  // ----
  initial
  begin
    reset_n_in = 1'b0;
    sdram_top_in = 32'h01000000;
    cpu_req_in = '0;
    // three full rising edges in reset before release
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    cpu_rd(1'b1, 32'h0000fffc, smd_pkg::CONFIG_REGION_BASE_RESET);
    cpu_rd(1'b0, 32'hfffef088, smd_pkg::DESC_RESET);
    cpu_route(1'b1, 32'h00000000, smd_pkg::RT_PCAT_IO);
    cpu_route(1'b1, 32'h000003ff, smd_pkg::RT_PCAT_IO);
    cpu_route(1'b1, 32'h00000400, smd_pkg::RT_PCI_IO);
    cpu_route(1'b1, 32'h00000cf7, smd_pkg::RT_PCI_IO);
    cpu_route(1'b1, 32'h00000cf8, smd_pkg::RT_PCI_CFG);
    cpu_route(1'b1, 32'h00000cff, smd_pkg::RT_PCI_CFG);
    cpu_route(1'b1, 32'h0000fffb, smd_pkg::RT_PCI_IO);
    cpu_route(1'b1, 32'h0000ffff, smd_pkg::RT_CONFIG_REGION_BASE);
    cpu_route(1'b0, 32'h00ffffff, smd_pkg::RT_SDRAM);
    cpu_route(1'b0, 32'h01000000, smd_pkg::RT_PCI_MEM);
    cpu_route(1'b0, 32'hfffeefff, smd_pkg::RT_PCI_MEM);
    cpu_route(1'b0, 32'hfffef000, smd_pkg::RT_MAPPED_CONFIG_REGION);
    cpu_route(1'b0, 32'hfffeffff, smd_pkg::RT_MAPPED_CONFIG_REGION);
    cpu_route(1'b0, 32'hffff0000, smd_pkg::RT_ROM_BOOT);
    cpu_route(1'b0, 32'hffffffff, smd_pkg::RT_ROM_BOOT);
    pci(1'b0, 1'b0, 32'h01000000, 4'h8);
    sdram_top_in = 32'h20000000;
    cpu_route(1'b0, 32'h0fffffff, smd_pkg::RT_SDRAM);
    cpu_route(1'b0, 32'h10000000, smd_pkg::RT_PCI_MEM);
    cpu_go(1'b1, 1'b1, 32'h0000fffc, 32'hffffffff);
    cpu_rd(1'b1, 32'h0000fffc, smd_pkg::CONFIG_REGION_BASE_WR_MASK);
    // alias kept clear of the pci windows set up below
    cpu_go(1'b1, 1'b1, 32'h0000fffc, 32'h80100000);
    cpu_route(1'b0, 32'h00100ffc, smd_pkg::RT_MAPPED_CONFIG_REGION);
    cpu_route(1'b0, 32'h00101000, smd_pkg::RT_SDRAM);
    cpu_route(1'b0, 32'hfffef000, smd_pkg::RT_MAPPED_CONFIG_REGION);
    cpu_go(1'b0, 1'b1, 32'h00100088, 32'h60000010);
    cpu_rd(1'b0, 32'hfffef088, 32'h60000010);
    desc_wr(1, 32'he4040010);
    desc_wr(2, 32'h54002000);
    desc_wr(3, 32'h60000020);
    desc_wr(4, 32'h2c0f0500);
    desc_wr(5, 32'h2c0f0100);
    desc_wr(6, 32'h4007ffff);
    desc_wr(7, 32'h44002000);
    desc_wr(15, 32'h48003000);
    cpu_rd(1'b0, 32'hfffef0c4, 32'h48003000);
    cpu_go(1'b0, 1'b1, 32'hfffef0c8, 32'hffffffff);
    cpu_rd(1'b0, 32'hfffef0c8, 32'h00000000);
    cpu_route(1'b0, 32'h00010000, smd_pkg::RT_PCI_MEM);
    cpu_route(1'b0, 32'h00011000, smd_pkg::RT_SDRAM);
    cmp_word("write protect", 32'h1, 32'(cpu_resp_out.write_protect));
    cmp_word("nonexec", 32'h0, 32'(cpu_resp_out.nonexec));
    cpu_route(1'b0, 32'h00020000, smd_pkg::RT_SDRAM);
    cpu_route(1'b0, 32'h02000fff, smd_pkg::RT_GP_MEM);
    cmp_word("gp attrs", 32'hb, {28'h0, cpu_resp_out.chip_sel, cpu_resp_out.noncache});
    cpu_route(1'b0, 32'h02001000, smd_pkg::RT_SDRAM);
    cpu_route(1'b0, 32'h03000000, smd_pkg::RT_GP_MEM);
    cpu_route(1'b0, 32'h3ffff000, smd_pkg::RT_PCI_MEM);
    cpu_route(1'b1, 32'h0000050f, smd_pkg::RT_GP_IO);
    cmp_word("gp io select", 32'h3, 32'(cpu_resp_out.chip_sel));
    cpu_route(1'b1, 32'h00000510, smd_pkg::RT_PCI_IO);
    cpu_route(1'b1, 32'h00000100, smd_pkg::RT_PCAT_IO);
    pci(1'b1, 1'b0, 32'h00011000, 4'hf);
    pci(1'b0, 1'b0, 32'h00011000, 4'hc);
    pci(1'b1, 1'b0, 32'h00010000, 4'h8);
    pci(1'b1, 1'b0, 32'h02000000, 4'hf);
    pci(1'b0, 1'b0, 32'h00000100, 4'hc);
    pci(1'b0, 1'b1, 32'h00000505, 4'h8);
    @(negedge ref_clk_in);
    reset_n_in = 1'b0;
    @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    cpu_rd(1'b0, 32'hfffef088, smd_pkg::DESC_RESET);
    cpu_route(1'b0, 32'h00100ffc, smd_pkg::RT_SDRAM);
    complete_run();
  end
endmodule // test_smd_addr_decoder
